/* File: hdl/shp_defs.vh */
`ifndef SHP_DEFS_VH
`define SHP_DEFS_VH
// ----------------------------------------
// frame layout
// ----------------------------------------
`define SHP_FRAME_BITS 32
`define SHP_CNT_W 6
`define SHP_ADDR_MSB 31
`define SHP_ADDR_LSB 25
`define SHP_RW_BIT 24
`define SHP_DATA_W 24
// ----------------------------------------
// reference clock timing
// ----------------------------------------
`define SHP_REF_FREQ_HZ 32768
`define SHP_SYS_FREQ_HZ 10000000
`define SHP_REF_PERIOD_NS 30518
// ----------------------------------------
// reset values
// ----------------------------------------
`define SHP_SO_RST 1'b0
`define SHP_OE_N_RST 1'b1
`define SHP_IRQ_N_RST 1'b1
`endif

/* File: hdl/shp_sync.v */
// ----------------------------------------
// two flop synchroniser for one level
// ----------------------------------------
module shp_sync #(
	parameter RST_VAL = 1'b0
) (
	input wire sys_clk_in,
	input wire nrst_in,
	input wire d_in,
	output reg q_out
);
	reg meta_reg; // first stage, read only by second stage

	// two stages, synchronous reset
	always @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			meta_reg <= RST_VAL;
			q_out <= RST_VAL;
		end else begin
			meta_reg <= d_in;
			q_out <= meta_reg;
		end
	end
endmodule // shp_sync

/* File: hdl/shp_port.v */
`include "shp_defs.vh"

module shp_port #(
	parameter FRAME_BITS = `SHP_FRAME_BITS,
	parameter DATA_W = `SHP_DATA_W
) (
	input wire sys_clk_in,
	input wire nrst_in,
	input wire port_select_n_in,
	input wire serial_clock_in,
	input wire serial_data_in,
	input wire ref_clock_in,
	input wire [DATA_W-1:0] read_data_in,
	input wire irq_primary_req_in,
	input wire irq_secondary_req_in,
	output reg serial_data_out,
	output reg serial_data_oe_n_out,
	output reg irq_primary_n_out,
	output reg irq_secondary_n_out,
	output reg [6:0] frame_addr_out,
	output reg frame_read_out,
	output reg [DATA_W-1:0] write_data_out,
	output reg write_strobe_out,
	output reg frame_start_out,
	output reg sample_tick_out
);
	// ----------------------------------------
	// synchronised pins
	// ----------------------------------------
	wire sel_n_s; // select, synced
	wire sck_s; // serial clock, synced
	wire sdi_s; // serial input, synced
	wire ref_s; // reference clock, synced

	// select resets high so no false frame start follows reset
	shp_sync #(.RST_VAL(1'b1)) u_sel (
		.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in),
		.d_in(port_select_n_in),
		.q_out(sel_n_s)
	);
	// serial clock resets low, its idle level between frames
	shp_sync #(.RST_VAL(1'b0)) u_sck (
		.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in),
		.d_in(serial_clock_in),
		.q_out(sck_s)
	);
	// serial input, read only when a rising edge is seen
	shp_sync #(.RST_VAL(1'b0)) u_sdi (
		.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in),
		.d_in(serial_data_in),
		.q_out(sdi_s)
	);
	// reference clock, free running, sampled like any pin
	shp_sync #(.RST_VAL(1'b0)) u_ref (
		.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in),
		.d_in(ref_clock_in),
		.q_out(ref_s)
	);

	// ----------------------------------------
	// edge detection
	// ----------------------------------------
	reg sel_n_d_reg; // previous select
	reg sck_d_reg; // previous serial clock
	reg ref_d_reg; // previous reference clock

	// reset values equal the idle pin levels, so no false edge follows reset
	// delay synced levels one cycle
	always @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			sel_n_d_reg <= 1'b1;
			sck_d_reg <= 1'b0;
			ref_d_reg <= 1'b0;
		end else begin
			sel_n_d_reg <= sel_n_s;
			sck_d_reg <= sck_s;
			ref_d_reg <= ref_s;
		end
	end

	// serial edges count only while the synced select is low, so
	// stray clocks between frames never move the shift state
	wire active = ~sel_n_s; // frame open
	wire sel_fall = sel_n_d_reg & ~sel_n_s; // frame begins
	wire sel_rise = ~sel_n_d_reg & sel_n_s; // frame ends
	wire sck_rise = active & ~sck_d_reg & sck_s;
	wire sck_fall = active & sck_d_reg & ~sck_s;
	wire ref_rise = ~ref_d_reg & ref_s;

	// ----------------------------------------
	// shift state
	// ----------------------------------------
	// only the bit counter is cleared at select high; received bits and latched header stay
	reg [FRAME_BITS-1:0] rx_reg; // received bits
	reg [FRAME_BITS-1:0] rx_next;
	reg [`SHP_CNT_W-1:0] cnt_reg; // rising edges seen
	reg [`SHP_CNT_W-1:0] cnt_next;
	reg [DATA_W-1:0] tx_reg; // bits left to send
	reg [DATA_W-1:0] tx_next;
	reg so_next;
	reg oe_n_next;
	reg [6:0] addr_next;
	reg rd_next;
	reg [DATA_W-1:0] wd_next;
	reg ws_next;

	// ----------------------------------------
	// frame milestones, cut to the counter width
	// ----------------------------------------
	localparam [`SHP_CNT_W-1:0] CNT_FULL = FRAME_BITS[`SHP_CNT_W-1:0]; // complete frame
	localparam [`SHP_CNT_W-1:0] CNT_HDR = FRAME_BITS[`SHP_CNT_W-1:0] - DATA_W[`SHP_CNT_W-1:0]; // header done

	// next state of the serial engine
	always @* begin
		// hold everything by default; the strobe is a single-cycle pulse
		rx_next = rx_reg;
		cnt_next = cnt_reg;
		tx_next = tx_reg;
		so_next = serial_data_out;
		oe_n_next = serial_data_oe_n_out;
		addr_next = frame_addr_out;
		rd_next = frame_read_out;
		wd_next = write_data_out;
		ws_next = 1'b0;
		// select high ends a frame or keeps the port idle
		if (sel_n_s) begin
			// select high: release output, forget partial frame
			oe_n_next = `SHP_OE_N_RST;
			cnt_next = {`SHP_CNT_W{1'b0}};
			if (sel_rise && cnt_reg == CNT_FULL && !rx_reg[FRAME_BITS-8]) begin
				// write only after full frame; early rise aborts
				wd_next = rx_reg[DATA_W-1:0];
				ws_next = 1'b1;
			end
		end else begin
			// select low: drive the output and follow the serial clock
			oe_n_next = 1'b0; // drive while selected
			if (sck_rise && cnt_reg != CNT_FULL) begin
				// shift in msb first
				rx_next = {rx_reg[FRAME_BITS-2:0], sdi_s};
				cnt_next = cnt_reg + 1'b1;
				// eighth bit closes the header: latch address and read flag
				if (cnt_reg + 1'b1 == CNT_HDR) begin
					addr_next = rx_reg[6:0];
					rd_next = sdi_s;
					tx_next = read_data_in;
				end
			end
			// falling edge: only read frames past the header drive data
			if (sck_fall) begin
				if (cnt_reg >= CNT_HDR && cnt_reg != CNT_FULL && rd_next) begin
					// present next data bit msb first
					so_next = tx_reg[DATA_W-1];
					tx_next = {tx_reg[DATA_W-2:0], 1'b0};
				end else begin
					// header, write frame or frame end: output rests low
					so_next = 1'b0;
				end
			end
		end
	end

	// ----------------------------------------
	// serial engine registers
	// ----------------------------------------
	// register the serial engine
	always @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			rx_reg <= {FRAME_BITS{1'b0}};
			cnt_reg <= {`SHP_CNT_W{1'b0}};
			tx_reg <= {DATA_W{1'b0}};
			serial_data_out <= `SHP_SO_RST;
			serial_data_oe_n_out <= `SHP_OE_N_RST;
			frame_addr_out <= 7'h00;
			frame_read_out <= 1'b0;
			write_data_out <= {DATA_W{1'b0}};
			write_strobe_out <= 1'b0;
			frame_start_out <= 1'b0;
		end else begin
			rx_reg <= rx_next;
			cnt_reg <= cnt_next;
			tx_reg <= tx_next;
			serial_data_out <= so_next;
			serial_data_oe_n_out <= oe_n_next;
			frame_addr_out <= addr_next;
			frame_read_out <= rd_next;
			write_data_out <= wd_next;
			write_strobe_out <= ws_next;
			// frame start marks the synced select fall
			frame_start_out <= sel_fall;
		end
	end

	// ----------------------------------------
	// interrupts and sample pacing
	// ----------------------------------------
	// drive interrupt pins low while a condition is pending
	always @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			irq_primary_n_out <= `SHP_IRQ_N_RST;
			irq_secondary_n_out <= `SHP_IRQ_N_RST;
			sample_tick_out <= 1'b0;
		end else begin
			// pins follow the inverted request levels one cycle later
			irq_primary_n_out <= ~irq_primary_req_in;
			irq_secondary_n_out <= ~irq_secondary_req_in;
			// one pulse per reference rising edge paces the converters
			sample_tick_out <= ref_rise;
		end
	end
endmodule // shp_port

/* File: test/shp_port_sva.sv */
module shp_port_sva (
	input wire sys_clk_in,
	input wire nrst_in,
	input wire port_select_n_in,
	input wire serial_clock_in,
	input wire ref_clock_in,
	input wire irq_primary_req_in,
	input wire irq_secondary_req_in,
	input wire serial_data_out,
	input wire serial_data_oe_n_out,
	input wire irq_primary_n_out,
	input wire irq_secondary_n_out,
	input wire frame_read_out,
	input wire write_strobe_out,
	input wire sample_tick_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);
	// select held long enough to clear the synchroniser
	sequence sel_idle;
		port_select_n_in [*5];
	endsequence
	sequence sel_busy;
		!port_select_n_in [*5];
	endsequence
	AST_OE_OFF: assert property (sel_idle |-> serial_data_oe_n_out) else $error("oe idle");
	AST_OE_ON: assert property (sel_busy |-> !serial_data_oe_n_out) else $error("oe busy");
	AST_SO_FALL: assert property (!serial_data_oe_n_out && $changed(serial_data_out) |-> !$past(serial_clock_in, 3))
		else $error("so edge");
	AST_IRQ1: assert property (1 |=> irq_primary_n_out != $past(irq_primary_req_in)) else $error("irq1");
	AST_IRQ2: assert property (1 |=> irq_secondary_n_out != $past(irq_secondary_req_in)) else $error("irq2");
	AST_STB: assert property (write_strobe_out |-> !frame_read_out && $past(port_select_n_in, 3)) else $error("stb");
	AST_STB1: assert property (write_strobe_out |=> !write_strobe_out) else $error("stb len");
	AST_TICK: assert property ($rose(ref_clock_in) |-> ##[2:5] $rose(sample_tick_out)) else $error("tick");
endmodule // shp_port_sva

/* File: test/shp_host_model.sv */
module shp_host_model (
	input wire sys_clk_in,
	input wire sdo_in,
	output logic sel_n_out = 1'b1,
	output logic sclk_out = 1'b0,
	output logic sdi_out = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	// one frame of n rising edges, sclk idles low
	task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
		rx = '0;
		@(negedge sys_clk_in) sel_n_out = 1'b0;
		for (int i = 0; i < n; i++) begin
			sdi_out = tx[31-i];
			repeat (4) @(negedge sys_clk_in);
			// take the bit launched by the last fall at this rise
			rx = {rx[30:0], sdo_in};
			sclk_out = 1'b1;
			repeat (4) @(negedge sys_clk_in);
			sclk_out = 1'b0;
		end
		repeat (4) @(negedge sys_clk_in);
		sel_n_out = 1'b1;
		sdi_out = ~sdi_out;
		repeat (6) @(negedge sys_clk_in);
	endtask
endmodule // shp_host_model

/* File: test/serial_host_port_pins_tb_top.sv */
module serial_host_port_pins_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, nrst = 0, rclk = 0, q1 = 0, q2 = 0;
	logic [23:0] rd = '0;
	logic [31:0] tx, rx;
	wire sn, sc, si, so, oe, i1, i2, rf, stb, fs, tk;
	wire [6:0] ad;
	wire [23:0] wd;
	// released line shows the inverse of the held bit
	wire sdo = so ^ oe;
	int failures = 0, n_checks = 0, ns = 0;
	logic [23:0] wq[$]; // expected write data, oldest first
	shp_port u_shp_port (.sys_clk_in(clk), .nrst_in(nrst), .port_select_n_in(sn), .serial_clock_in(sc),
		.serial_data_in(si), .ref_clock_in(rclk), .read_data_in(rd), .irq_primary_req_in(q1),
		.irq_secondary_req_in(q2), .serial_data_out(so), .serial_data_oe_n_out(oe), .irq_primary_n_out(i1),
		.irq_secondary_n_out(i2), .frame_addr_out(ad), .frame_read_out(rf), .write_data_out(wd),
		.write_strobe_out(stb), .frame_start_out(fs), .sample_tick_out(tk));
	shp_host_model u_host (.sys_clk_in(clk), .sdo_in(sdo), .sel_n_out(sn), .sclk_out(sc), .sdi_out(si));
	always #50 clk = ~clk;
	always #15259 @(negedge clk) rclk = ~rclk;
	// bench model: every executed write pops the data it must carry
	always @(negedge clk) begin
		if (stb === 1'b1) begin
			ns <= ns + 1;
			if (wq.size() == 0)
				chk(stb, 0);
			else
				chk(wd, wq.pop_front());
		end
	end
	// each reference rise gives one tick pulse three cycles on
	always @(posedge rclk) begin
		repeat (3) @(negedge clk);
		chk(tk, 1);
		@(negedge clk);
		chk(tk, 0);
	end
	// each select fall gives one frame start pulse
	always @(negedge sn) begin
		repeat (3) @(negedge clk);
		chk(fs, 1);
		@(negedge clk);
		chk(fs, 0);
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %0t got %h want %h", $time, s, e);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// one frame against the bench model, short frames abort
	task automatic frame(input logic r, input int n);
		int s;
		s = ns;
		tx = $urandom;
		tx[24] = r;
		rd = $urandom;
		if (n == 32 && !r) wq.push_back(tx[23:0]);
		u_host.xfer(tx, n, rx);
		chk(ns - s, n == 32 && !r);
		chk(oe, 1);
		if (n == 32) begin
			chk(ad, tx[31:25]);
			chk(rf, r);
			chk(r ? rx[23:0] : wd, r ? rd : tx[23:0]);
		end
	endtask
	initial begin
		void'($urandom(32));
		repeat (4) @(negedge clk);
		nrst = 1;
		for (int k = 0; k < 8; k++) begin
			frame(k[0], k < 6 ? 32 : 31);
			q1 = $urandom;
			q2 = $urandom;
			@(negedge clk);
			chk({i1, i2}, {~q1, ~q2});
		end
		chk(wq.size(), 0);
		tally_and_finish;
	end
endmodule // serial_host_port_pins_tb_top
bind shp_port shp_port_sva u_sva (.*);
